// ===== src/scm_cfg.svh
// constants of the serial channel mode block
// assumes a 32-bit ahb-lite bus, one word per register
`ifndef SCM_CFG_SVH
`define SCM_CFG_SVH
// register indexes; byte address is four times the index
`define SCM_IDX_MODE 8'hb0
`define SCM_IDX_RATE 8'hb1
`define SCM_IDX_CTRL 8'hb2
`define SCM_IDX_DATA 8'hc0
`define SCM_IDX_STAT 8'hc1
`define SCM_IDX_MASK 8'hc2
// reset values
`define SCM_RST_MODE 8'h00
`define SCM_RST_RATE 8'hff
`define SCM_RST_CTRL 8'h00
`define SCM_RST_STAT 4'h0
`define SCM_RST_MASK 4'h0
// status bit positions
`define SCM_ST_TXE 0
`define SCM_ST_TXEND 1
`define SCM_ST_RXF 2
`define SCM_ST_RXERR 3
// data word: transmit multiprocessor bit position
`define SCM_DATA_MPB 8
// prescaler terminal counts: /1 /4 /16 /64
`define SCM_PRE_0 6'd0
`define SCM_PRE_1 6'd3
`define SCM_PRE_2 6'd15
`define SCM_PRE_3 6'd63
`endif

// ===== src/scm_pkg.sv
// types of the serial channel mode block
// no assumptions beyond the header constants
package scm_pkg;
	// mode register layout, bit 7 first
	typedef struct packed {
		logic sync_mode;
		logic char_length_select;
		logic parity_enable;
		logic odd_parity;
		logic two_stop;
		logic multiproc_format;
		logic prescale_select_hi;
		logic prescale_select_lo;
	} scm_mode_type;
	// control register layout, bit 7 first
	typedef struct packed {
		logic tx_empty_irq_en;
		logic rx_irq_en;
		logic tx_enable;
		logic rx_enable;
		logic multiproc_irq_en;
		logic tx_end_irq_en;
		logic clock_pin_select_hi;
		logic clock_pin_select_lo;
	} scm_ctrl_type;
	// the four gated request lines
	typedef struct packed {
		logic tx_empty_irq;
		logic tx_end_irq;
		logic rx_full_irq;
		logic rx_error_irq;
	} scm_irq_type;
	typedef enum logic {SCM_TX_IDLE, SCM_TX_SHIFT} scm_tx_type;
	typedef enum logic {SCM_RX_IDLE, SCM_RX_SHIFT} scm_rx_type;
endpackage

// ===== src/scm_serial_channel.sv
// serial channel zero: mode, rate, control and a small uart
// assumes ahb-lite master, pins synchronous to clk_sys
//
// The AHB-Lite slave port was decided locally.
`timescale 1ns/10ps
`default_nettype none
`include "scm_cfg.svh"
// Function
// - mode bit picks async or clocked sync
// - parity enable adds and checks parity
// - parity sense: 0 even, 1 odd
// - stop bit: one or two stop bits
// - multiprocessor bit adds multiprocessor format
// - prescaler field 00 uses undivided clock
// - eight bit rate register, resets all ones
// - both clock bits zero: internal clock
// - lower bit set: internal clock, pin out
// - upper bit set: pin is clock input
// - transmit end request gated by enable
// - multiprocessor enable filters received characters
// - receive full and error gated by enable
// - transmit empty request gated by enable
module scm_serial_channel (
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	input wire logic rxd,
	output logic txd,
	input wire logic sck_i,
	output logic sck_o,
	output logic sck_oe,
	output scm_pkg::scm_irq_type irq_lines,
	output logic irq
);
	// registers software sees
	scm_pkg::scm_mode_type mode_ff; // serial_mode_reg
	logic [7:0] rate_ff; // bit_rate_reg
	scm_pkg::scm_ctrl_type ctrl_ff; // serial_control_reg
	logic [3:0] stat_ff; // sticky events
	logic [3:0] mask_ff; // interrupt mask
	logic [11:0] rxword_ff; // flags and last char
	// bus data phase
	logic ap_wr_ff;
	logic ap_rd_ff;
	logic [7:0] ap_idx_ff;
	logic [31:0] hrdata_ff;
	logic hreadyout_ff;
	// clocking
	logic [5:0] pre_cnt_ff;
	logic [7:0] brr_cnt_ff;
	logic sck_ff;
	logic sck_prev_ff;
	logic sck_oe_ff;
	// transmitter
	scm_pkg::scm_tx_type tx_st_ff;
	logic [12:0] tx_sr_ff;
	logic [3:0] tx_cnt_ff;
	logic [8:0] tx_buf_ff; // mp bit and char
	logic tx_pend_ff;
	logic txd_ff;
	// receiver
	scm_pkg::scm_rx_type rx_st_ff;
	logic [12:0] rx_sr_ff;
	logic [3:0] rx_idx_ff;
	logic rx_done_ff;
	// outputs
	scm_pkg::scm_irq_type irq_lines_ff;
	logic irq_ff;

	// frame bit count, start and stop included
	function automatic logic [3:0] frame_len(scm_pkg::scm_mode_type m);
		if (m.sync_mode) begin
			frame_len = 4'd8;
		end else begin
			frame_len = 4'd10 - 4'(m.char_length_select) + 4'(m.parity_enable)
				+ 4'(m.multiproc_format) + 4'(m.two_stop);
		end
	endfunction

	// parity over the live data bits
	function automatic logic par_of(scm_pkg::scm_mode_type m, logic [7:0] d);
		logic [7:0] msk;
		msk = m.char_length_select ? 8'h7f : 8'hff;
		par_of = (^(d & msk)) ^ m.odd_parity;
	endfunction

	// lsb-first frame image; idle ones fill the stop bits
	function automatic logic [12:0] compose(scm_pkg::scm_mode_type m, logic [8:0] b);
		logic [12:0] v;
		logic [3:0] p;
		v = 13'h1fff;
		p = 4'd1;
		if (m.sync_mode) begin
			v[7:0] = b[7:0];
		end else begin
			v[0] = 1'b0; // start bit
			for (int i = 0; i < 8; i++) begin
				if (i < 7 || !m.char_length_select) begin
					v[p] = b[i];
					p = p + 4'd1;
				end
			end
			if (m.parity_enable) begin
				v[p] = par_of(m, b[7:0]);
				p = p + 4'd1;
			end
			if (m.multiproc_format) begin
				v[p] = b[`SCM_DATA_MPB];
			end
		end
		compose = v;
	endfunction

	// prescaler terminal count
	function automatic logic [5:0] pre_lim(logic [1:0] s);
		case (s)
			2'b00: pre_lim = `SCM_PRE_0;
			2'b01: pre_lim = `SCM_PRE_1;
			2'b10: pre_lim = `SCM_PRE_2;
			default: pre_lim = `SCM_PRE_3;
		endcase
	endfunction

	// bus decode
	wire logic ap_take = hsel & htrans[1] & hready;
	wire logic [7:0] a_idx = haddr[9:2];
	wire logic wr_mode = ap_wr_ff & (ap_idx_ff == `SCM_IDX_MODE);
	wire logic wr_rate = ap_wr_ff & (ap_idx_ff == `SCM_IDX_RATE);
	wire logic wr_ctrl = ap_wr_ff & (ap_idx_ff == `SCM_IDX_CTRL);
	wire logic wr_data = ap_wr_ff & (ap_idx_ff == `SCM_IDX_DATA);
	wire logic wr_stat = ap_wr_ff & (ap_idx_ff == `SCM_IDX_STAT);
	wire logic wr_mask = ap_wr_ff & (ap_idx_ff == `SCM_IDX_MASK);
	// read mux; unmapped words read zero
	wire logic [31:0] rd_mux =
		(a_idx == `SCM_IDX_MODE) ? {24'h0, mode_ff} :
		(a_idx == `SCM_IDX_RATE) ? {24'h0, rate_ff} :
		(a_idx == `SCM_IDX_CTRL) ? {24'h0, ctrl_ff} :
		(a_idx == `SCM_IDX_DATA) ? {20'h0, rxword_ff} :
		(a_idx == `SCM_IDX_STAT) ? {28'h0, stat_ff} :
		(a_idx == `SCM_IDX_MASK) ? {28'h0, mask_ff} : 32'h0;

	// bit clock source
	wire logic [1:0] pre_sel = {mode_ff.prescale_select_hi, mode_ff.prescale_select_lo};
	wire logic pre_hit = (pre_cnt_ff == pre_lim(pre_sel));
	wire logic int_tick = pre_hit & (brr_cnt_ff == 8'h00);
	wire logic ext_clk = ctrl_ff.clock_pin_select_hi;
	wire logic tx_busy = (tx_st_ff == scm_pkg::SCM_TX_SHIFT);
	// sync internal clock idles high between characters while the receiver is disabled
	wire logic sck_run = !mode_ff.sync_mode | tx_busy | ctrl_ff.rx_enable;
	wire logic bit_tick = ext_clk ? (sck_i & ~sck_prev_ff)
		: (int_tick & sck_run & ~sck_ff);
	wire logic [3:0] flen = frame_len(mode_ff);

	// transmit control
	wire logic tx_load = ctrl_ff.tx_enable & tx_pend_ff
		& (!tx_busy | (bit_tick & tx_cnt_ff == 4'd0));
	wire logic tx_end_ev = tx_busy & bit_tick & (tx_cnt_ff == 4'd0) & !tx_pend_ff;

	// receive decode from the captured frame
	wire logic [7:0] rx_nd = mode_ff.char_length_select ? 8'h7f : 8'hff;
	wire logic [7:0] rx_data = mode_ff.sync_mode ? rx_sr_ff[7:0] : (rx_sr_ff[8:1] & rx_nd);
	wire logic [3:0] rx_pi = mode_ff.char_length_select ? 4'd8 : 4'd9;
	wire logic [3:0] rx_mi = rx_pi + 4'(mode_ff.parity_enable);
	wire logic [3:0] rx_si = rx_mi + 4'(mode_ff.multiproc_format);
	wire logic rx_mpb = !mode_ff.sync_mode & mode_ff.multiproc_format & rx_sr_ff[rx_mi];
	wire logic rx_perr = !mode_ff.sync_mode & mode_ff.parity_enable
		& (rx_sr_ff[rx_pi] != par_of(mode_ff, rx_data));
	wire logic rx_ferr = !mode_ff.sync_mode & !rx_sr_ff[rx_si];
	// skip data characters while waiting for an id character
	wire logic rx_skip = mode_ff.multiproc_format & ctrl_ff.multiproc_irq_en
		& !mode_ff.sync_mode & !rx_mpb;
	wire logic rx_accept = rx_done_ff & !rx_skip;
	wire logic rx_ovr = rx_accept & stat_ff[`SCM_ST_RXF];

	// sticky events; a set in the clearing cycle wins
	wire logic [3:0] ev = {rx_accept & (rx_perr | rx_ferr | rx_ovr), rx_accept, tx_end_ev, tx_load};
	wire logic [3:0] nxt_stat = (stat_ff & ~(wr_stat ? hwdata[3:0] : 4'h0)) | ev;
	wire scm_pkg::scm_irq_type nxt_lines = '{
		tx_empty_irq: stat_ff[`SCM_ST_TXE] & ctrl_ff.tx_empty_irq_en,
		tx_end_irq: stat_ff[`SCM_ST_TXEND] & ctrl_ff.tx_end_irq_en,
		rx_full_irq: stat_ff[`SCM_ST_RXF] & ctrl_ff.rx_irq_en,
		rx_error_irq: stat_ff[`SCM_ST_RXERR] & ctrl_ff.rx_irq_en};
	// mask keeps the status layout, tx empty at bit 0
	wire logic nxt_irq = |({nxt_lines.rx_error_irq, nxt_lines.rx_full_irq,
		nxt_lines.tx_end_irq, nxt_lines.tx_empty_irq} & mask_ff);
	// pin drives only for internal clock, except async with lower bit clear
	wire logic nxt_sck_oe = !ctrl_ff.clock_pin_select_hi
		& (ctrl_ff.clock_pin_select_lo | mode_ff.sync_mode);

	// ahb address phase capture and zero-wait read data
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			ap_wr_ff <= 1'b0;
			ap_rd_ff <= 1'b0;
			ap_idx_ff <= 8'h00;
			hrdata_ff <= 32'h0;
			hreadyout_ff <= 1'b0;
		end else begin
			ap_wr_ff <= ap_take & hwrite;
			ap_rd_ff <= ap_take & !hwrite;
			ap_idx_ff <= a_idx;
			hrdata_ff <= (ap_take & !hwrite) ? rd_mux : 32'h0;
			hreadyout_ff <= 1'b1;
		end
	end

	// software registers
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			mode_ff <= `SCM_RST_MODE;
			rate_ff <= `SCM_RST_RATE;
			ctrl_ff <= `SCM_RST_CTRL;
			mask_ff <= `SCM_RST_MASK;
			stat_ff <= `SCM_RST_STAT;
		end else begin
			if (wr_mode) begin
				mode_ff <= hwdata[7:0];
			end
			if (wr_rate) begin
				rate_ff <= hwdata[7:0];
			end
			if (wr_ctrl) begin
				ctrl_ff <= hwdata[7:0];
			end
			if (wr_mask) begin
				mask_ff <= hwdata[3:0];
			end
			stat_ff <= nxt_stat;
		end
	end

	// prescaler then rate divider
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			pre_cnt_ff <= 6'd0;
			brr_cnt_ff <= 8'hff;
		end else if (pre_hit) begin
			pre_cnt_ff <= 6'd0;
			brr_cnt_ff <= (brr_cnt_ff == 8'h00) ? rate_ff : brr_cnt_ff - 8'h01;
		end else begin
			pre_cnt_ff <= pre_cnt_ff + 6'd1;
		end
	end

	// serial clock pin; edges of the input are sampled directly
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			sck_ff <= 1'b1;
			sck_prev_ff <= 1'b1;
			sck_oe_ff <= 1'b0;
		end else begin
			sck_prev_ff <= sck_i;
			sck_oe_ff <= nxt_sck_oe;
			if (!sck_run | ext_clk) begin
				sck_ff <= 1'b1;
			end else if (int_tick) begin
				sck_ff <= ~sck_ff;
			end
		end
	end

	// transmit buffer: last write wins until loaded
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			tx_buf_ff <= 9'h000;
			tx_pend_ff <= 1'b0;
		end else if (wr_data) begin
			tx_buf_ff <= hwdata[8:0];
			tx_pend_ff <= 1'b1;
		end else if (tx_load) begin
			tx_pend_ff <= 1'b0;
		end
	end

	// transmit shifter; one extra tick holds the last bit
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			tx_st_ff <= scm_pkg::SCM_TX_IDLE;
			tx_sr_ff <= 13'h1fff;
			tx_cnt_ff <= 4'd0;
			txd_ff <= 1'b1;
		end else if (!ctrl_ff.tx_enable) begin
			tx_st_ff <= scm_pkg::SCM_TX_IDLE;
			txd_ff <= 1'b1;
		end else if (tx_load) begin
			tx_st_ff <= scm_pkg::SCM_TX_SHIFT;
			tx_sr_ff <= compose(mode_ff, tx_buf_ff);
			tx_cnt_ff <= flen;
		end else begin
			case (tx_st_ff)
				scm_pkg::SCM_TX_SHIFT: begin
					if (bit_tick & tx_cnt_ff == 4'd0) begin
						tx_st_ff <= scm_pkg::SCM_TX_IDLE;
					end else if (bit_tick) begin
						txd_ff <= tx_sr_ff[0];
						tx_sr_ff <= {1'b1, tx_sr_ff[12:1]};
						tx_cnt_ff <= tx_cnt_ff - 4'd1;
					end
				end
				default: begin
					txd_ff <= 1'b1;
				end
			endcase
		end
	end

	// receiver; sync samples from the first tick, async waits for start
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			rx_st_ff <= scm_pkg::SCM_RX_IDLE;
			rx_sr_ff <= 13'h0000;
			rx_idx_ff <= 4'd0;
			rx_done_ff <= 1'b0;
		end else begin
			rx_done_ff <= 1'b0;
			if (!ctrl_ff.rx_enable) begin
				rx_st_ff <= scm_pkg::SCM_RX_IDLE;
			end else if (bit_tick) begin
				case (rx_st_ff)
					scm_pkg::SCM_RX_IDLE: begin
						if (mode_ff.sync_mode | !rxd) begin
							rx_st_ff <= scm_pkg::SCM_RX_SHIFT;
							rx_sr_ff <= 13'h1fff;
							rx_sr_ff[0] <= rxd;
							rx_idx_ff <= 4'd1;
						end
					end
					scm_pkg::SCM_RX_SHIFT: begin
						rx_sr_ff[rx_idx_ff] <= rxd;
						rx_idx_ff <= rx_idx_ff + 4'd1;
						if (rx_idx_ff == flen - 4'd1) begin
							rx_st_ff <= scm_pkg::SCM_RX_IDLE;
							rx_done_ff <= 1'b1;
						end
					end
					default: begin
						rx_st_ff <= scm_pkg::SCM_RX_IDLE;
					end
				endcase
			end
		end
	end

	// received word: overrun, framing, parity, mp bit, char
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			rxword_ff <= 12'h000;
		end else if (rx_accept) begin
			rxword_ff <= {rx_ovr, rx_ferr, rx_perr, rx_mpb, rx_data};
		end
	end

	// request lines and the one masked interrupt
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			irq_lines_ff <= '0;
			irq_ff <= 1'b0;
		end else begin
			irq_lines_ff <= nxt_lines;
			irq_ff <= nxt_irq;
		end
	end

	assign hrdata = hrdata_ff;
	assign hreadyout = hreadyout_ff;
	assign hresp = 1'b0;
	assign txd = txd_ff;
	assign sck_o = sck_ff;
	assign sck_oe = sck_oe_ff;
	assign irq_lines = irq_lines_ff;
	assign irq = irq_ff;

	// checks
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rst_n);
	a_tx_end_gate: assert property (irq_lines.tx_end_irq |-> $past(ctrl_ff.tx_end_irq_en))
		else $error("tx end request while disabled");
	a_rx_irq_gate: assert property ((irq_lines.rx_full_irq | irq_lines.rx_error_irq)
		|-> $past(ctrl_ff.rx_irq_en))
		else $error("receive request while disabled");
	a_tx_empty_gate: assert property (irq_lines.tx_empty_irq |-> $past(ctrl_ff.tx_empty_irq_en))
		else $error("tx empty request while disabled");
	a_tx_off_idle: assert property (!ctrl_ff.tx_enable |=> txd)
		else $error("line active with transmit off");
	a_sck_ext_in: assert property (ctrl_ff.clock_pin_select_hi |=> !sck_oe)
		else $error("clock pin driven in external mode");
	a_sck_int_out: assert property (!ctrl_ff.clock_pin_select_hi & ctrl_ff.clock_pin_select_lo
		|=> sck_oe)
		else $error("clock pin not driven");
	a_sck_gpio: assert property (ctrl_ff[1:0] == 2'b00 & !mode_ff.sync_mode |=> !sck_oe)
		else $error("clock pin driven in async gpio mode");
	a_rate_hold: assert property (!wr_rate |=> $stable(rate_ff))
		else $error("rate changed without a write");
	a_pre_wrap: assert property (pre_cnt_ff <= pre_lim(pre_sel) |=> pre_cnt_ff <= pre_lim($past(pre_sel)))
		else $error("prescaler past its limit");
	a_frame_len: assert property (tx_load & ctrl_ff.tx_enable & !mode_ff.sync_mode
		|=> tx_cnt_ff == frame_len($past(mode_ff)) ##0 !tx_sr_ff[0])
		else $error("wrong frame length or start bit");
	c_tx_done: cover property (tx_end_ev);
	c_rx_accept: cover property (rx_accept);
	c_ext_tick: cover property (ext_clk & bit_tick);
	c_irq: cover property (irq);
endmodule
`default_nettype wire

// ===== sim/scm_peer.sv
// remote serial peer on the line: frame capture, frame send, pin clock
// assumes the bench sets the bit period in clk_sys cycles
`timescale 1ns/10ps
`default_nettype none
module scm_peer (
	input wire logic clk_sys,
	input wire logic txd,
	output logic rxd,
	output logic sck_i
);
	int per = 4; // bit period, clocks
	logic [15:0] frame = '1; // captured line bits, lsb first
	// line and clock pin idle high between frames
	initial begin
		rxd = 1'b1;
		sck_i = 1'b1;
	end
	// start edge, then one sample in the middle of each bit
	initial begin
		forever begin
			@(negedge txd);
			repeat (per / 2) @(posedge clk_sys);
			for (int i = 0; i < 16; i++) begin
				frame[i] = txd;
				repeat (per) @(posedge clk_sys);
			end
		end
	end
	// raw line bits, lsb first, each held one bit period
	task automatic send(input logic [15:0] b, input int n);
		for (int i = 0; i < n; i++) begin
			rxd <= b[i];
			repeat (per) @(posedge clk_sys);
		end
		rxd <= 1'b1;
	endtask
	// pin clock: one rising edge per bit period
	task automatic ticks(input int n);
		for (int i = 0; i < n; i++) begin
			sck_i <= 1'b0;
			repeat (per / 2) @(posedge clk_sys);
			sck_i <= 1'b1;
			repeat (per / 2) @(posedge clk_sys);
		end
	endtask
endmodule
`default_nettype wire

// ===== sim/tb_scm_serial_channel.sv
// bench for the serial channel mode block
// assumes the peer model on the line and a single ahb-lite master
`timescale 1ns/10ps
`default_nettype none
module tb_scm_serial_channel;
	localparam logic [31:0] A_MODE = 32'h2c0; // byte addresses
	localparam logic [31:0] A_RATE = 32'h2c4;
	localparam logic [31:0] A_CTRL = 32'h2c8;
	localparam logic [31:0] A_DATA = 32'h300;
	localparam logic [31:0] A_STAT = 32'h304;
	localparam logic [31:0] A_MASK = 32'h308;
	logic clk_sys, rst_n, hsel, hwrite, hreadyout, hresp;
	logic [31:0] haddr, hwdata, hrdata;
	logic [1:0] htrans;
	logic [2:0] hsize;
	logic rxd, txd, sck_i, sck_o, sck_oe, irq;
	scm_pkg::scm_irq_type irq_lines;
	logic [2:0] sigs; // polled lines
	int failures = 0;
	int n_tests = 0;
	assign sigs = {irq, irq_lines.tx_end_irq, txd};
	scm_serial_channel u_dut (.clk_sys(clk_sys), .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
		.hreadyout(hreadyout), .hresp(hresp), .rxd(rxd), .txd(txd), .sck_i(sck_i), .sck_o(sck_o),
		.sck_oe(sck_oe), .irq_lines(irq_lines), .irq(irq));
	scm_peer u_peer (.clk_sys(clk_sys), .txd(txd), .rxd(rxd), .sck_i(sck_i));
	// 10 MHz system clock
	initial begin
		clk_sys = 1'b0;
		forever #50 clk_sys = ~clk_sys;
	end
	task automatic final_report();
		$display("checks %0d mismatches %0d", n_tests, failures);
		if (failures == 0 && n_tests > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	// a wait ran out: count it and stop
	task automatic hang();
		failures++;
		final_report();
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
		n_tests++;
		if (got !== exp) begin
			failures++;
			$display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask
	// one single transfer; address held until hready, then data phase
	task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] wd, output logic [31:0] rd);
		int k;
		k = 0;
		hsel <= 1'b1;
		htrans <= 2'b10;
		haddr <= a;
		hwrite <= wr;
		do begin
			@(posedge clk_sys);
			k++;
		end while (hreadyout !== 1'b1 && k < 50);
		hsel <= 1'b0;
		htrans <= 2'b00;
		hwdata <= wd;
		do begin
			@(posedge clk_sys);
			k++;
		end while (hreadyout !== 1'b1 && k < 50);
		rd = hrdata;
		if (k >= 50)
			hang();
	endtask
	task automatic wr(input logic [31:0] a, input logic [31:0] d);
		logic [31:0] x;
		bus(1'b1, a, d, x);
	endtask
	task automatic rd(input logic [31:0] a, output logic [31:0] d);
		bus(1'b0, a, 32'h0, d);
	endtask
	// bounded wait for a polled line, k counts clocks
	task automatic await(input int s, input logic v, output int k);
		k = 0;
		while (sigs[s] !== v && k < 3000) begin
			@(posedge clk_sys);
			k++;
		end
		if (k >= 3000)
			hang();
	endtask
	// expected line bits of one async frame, idle ones after
	function automatic logic [15:0] exp_frame(input logic [7:0] m, input logic [8:0] d);
		logic [15:0] f;
		int n;
		f = '1;
		f[0] = 1'b0;
		n = m[6] ? 8 : 9;
		for (int i = 1; i < n; i++)
			f[i] = d[i - 1];
		if (m[5])
			f[n] = (m[6] ? ^d[6:0] : ^d[7:0]) ^ m[4];
		n = n + m[5];
		if (m[2])
			f[n] = d[8];
		return f;
	endfunction
	// configure, send one character, time start bit and frame end
	task automatic send_char(input logic [7:0] m, input logic [7:0] r, input logic [8:0] d, output int tl,
		output int te);
		int k;
		u_peer.per = 2 * (4 ** m[1:0]) * (r + 1);
		wr(A_MODE, {24'h0, m});
		wr(A_RATE, {24'h0, r});
		wr(A_CTRL, 32'h24);
		wr(A_STAT, 32'hf);
		wr(A_DATA, {23'h0, d});
		await(0, 1'b0, k);
		await(0, 1'b1, tl);
		await(1, 1'b1, te);
		te = te + tl;
		repeat (16 * u_peer.per) @(posedge clk_sys);
	endtask
	task automatic t_regs();
		logic [31:0] v;
		logic [31:0] ad [6] = '{A_MODE, A_RATE, A_CTRL, A_STAT, A_MASK, 32'h3fc};
		logic [31:0] rv [6] = '{32'h00, 32'hff, 32'h00, 32'h0, 32'h0, 32'h0};
		for (int i = 0; i < 6; i++) begin
			rd(ad[i], v);
			chk(v, rv[i], "reset value");
		end
		wr(A_RATE, 32'hffff_ff5a);
		rd(A_RATE, v);
		chk(v, 32'h5a, "rate readback");
		chk(hresp, 1'b0, "okay response");
		wr(32'h3fc, 32'h1);
		rd(32'h3fc, v);
		chk(v, 32'h0, "unmapped place");
		$display("done regs");
	endtask
	// every framing option, checked on the line and by frame length
	task automatic t_frame();
		logic [7:0] md [6] = '{8'h00, 8'h40, 8'h20, 8'h70, 8'h08, 8'h2c};
		logic [8:0] d;
		int tl, te, nb;
		for (int i = 0; i < 6; i++) begin
			d = i[0] ? 9'h0d3 : 9'h1a5;
			send_char(md[i], 8'h01, d, tl, te);
			nb = (md[i][6] ? 8 : 9) + md[i][5] + md[i][2] + (md[i][3] ? 2 : 1);
			chk(u_peer.frame, exp_frame(md[i], d), "frame bits");
			chk(te, nb * 4 + 1, "frame length");
		end
		$display("done frame");
	endtask
	// start bit width follows prescaler and rate register
	task automatic t_pre();
		int tl, te;
		for (int p = 0; p < 4; p++) begin
			send_char(p[7:0], 8'h00, 9'h001, tl, te);
			chk(tl, 2 * (4 ** p), "start width");
		end
		send_char(8'h00, 8'h02, 9'h001, tl, te);
		chk(tl, 6, "start width rate");
		$display("done prescale");
	endtask
	task automatic t_clk();
		logic [15:0] cfg [5] = '{16'h0000, 16'h0001, 16'h0002, 16'h0003, 16'h8000};
		logic [4:0] oe = 5'b10010; // expected pin enable, entry 0 at lsb
		for (int i = 0; i < 5; i++) begin
			wr(A_MODE, {24'h0, cfg[i][15:8]});
			wr(A_CTRL, {24'h0, cfg[i][7:0]});
			repeat (2) @(posedge clk_sys);
			chk(sck_oe, oe[i], "pin enable");
		end
		u_peer.per = 4;
		wr(A_MODE, 32'h0);
		wr(A_CTRL, 32'h26);
		wr(A_DATA, 32'h5c);
		repeat (20) @(posedge clk_sys);
		chk(txd, 1'b1, "idle without pin clock");
		u_peer.ticks(14);
		repeat (24) @(posedge clk_sys);
		chk(u_peer.frame, exp_frame(8'h00, 9'h05c), "pin clocked frame");
		// clocked sync: eight bits lsb first, no start or stop
		wr(A_RATE, 32'h1);
		wr(A_MODE, 32'h80);
		wr(A_CTRL, 32'h20);
		wr(A_DATA, 32'h5a);
		repeat (80) @(posedge clk_sys);
		chk(u_peer.frame, 32'hff5a, "sync frame");
		chk(sck_o, 1'b1, "sync clock idles high");
		$display("done clock");
	endtask
	// raise, mask, gate and clear the transmit requests
	task automatic t_irq();
		logic [31:0] v;
		int k;
		wr(A_MODE, 32'h0);
		wr(A_RATE, 32'h0);
		wr(A_CTRL, 32'h20);
		wr(A_STAT, 32'hf);
		wr(A_MASK, 32'h1);
		wr(A_DATA, 32'h33);
		repeat (4) @(posedge clk_sys);
		chk(irq_lines, 4'b0000, "empty gated");
		wr(A_CTRL, 32'ha0);
		await(2, 1'b1, k);
		chk(irq_lines, 4'b1000, "empty request");
		wr(A_MASK, 32'h0);
		repeat (2) @(posedge clk_sys);
		chk(irq, 1'b0, "masked");
		wr(A_MASK, 32'h1);
		wr(A_STAT, 32'h1);
		repeat (2) @(posedge clk_sys);
		chk(irq, 1'b0, "cleared");
		repeat (30) @(posedge clk_sys);
		rd(A_STAT, v);
		chk(v[1], 1'b1, "end sticky");
		chk(irq_lines.tx_end_irq, 1'b0, "end gated");
		$display("done irq");
	endtask
	// receive: gating, parity error, disabled, multiprocessor filter
	task automatic t_rx();
		logic [31:0] v;
		u_peer.per = 4;
		wr(A_MODE, 32'h20);
		wr(A_RATE, 32'h1);
		wr(A_CTRL, 32'h10);
		wr(A_STAT, 32'hf);
		u_peer.send({5'h1f, 1'b1, 1'b0, 8'h96, 1'b0}, 16);
		rd(A_STAT, v);
		chk(v[3:0], 4'b0100, "rx full");
		chk(irq_lines, 4'b0000, "rx gated");
		rd(A_DATA, v);
		chk(v[9:0], 10'h096, "rx char");
		wr(A_STAT, 32'hf);
		wr(A_CTRL, 32'h50);
		u_peer.send({5'h1f, 1'b1, 1'b1, 8'h96, 1'b0}, 16);
		chk(irq_lines, 4'b0011, "rx error request");
		rd(A_DATA, v);
		chk(v[9], 1'b1, "parity flag");
		wr(A_STAT, 32'hf);
		wr(A_CTRL, 32'h40);
		u_peer.send({5'h1f, 1'b1, 1'b0, 8'h96, 1'b0}, 16);
		rd(A_STAT, v);
		chk(v[3:0], 4'b0000, "rx disabled");
		wr(A_MODE, 32'h04);
		wr(A_CTRL, 32'h58);
		u_peer.send({5'h1f, 1'b1, 1'b0, 8'h41, 1'b0}, 16);
		rd(A_STAT, v);
		chk(v[3:0], 4'b0000, "data char dropped");
		u_peer.send({5'h1f, 1'b1, 1'b1, 8'h41, 1'b0}, 16);
		rd(A_DATA, v);
		chk(v[8:0], 9'h141, "id char kept");
		$display("done rx");
	endtask
	// reset for two clocks, then the scenarios
	initial begin
		rst_n = 1'b0;
		hsel = 1'b0;
		haddr = 32'h0;
		htrans = 2'b00;
		hwrite = 1'b0;
		hsize = 3'b010;
		hwdata = 32'h0;
		repeat (2) @(posedge clk_sys);
		rst_n <= 1'b1;
		@(posedge clk_sys);
		t_regs();
		t_frame();
		t_pre();
		t_clk();
		t_irq();
		t_rx();
		final_report();
	end
endmodule
`default_nettype wire
